// ===== design/charge_cfg_pkg.sv
/*
 Shared constants and types of the charge configuration register bank:
 register offsets, reset values, reset masks, field layouts and timer limits.
 Assumes one 25 MHz core clock and an external serial slave that hands over
 single-byte register accesses.
*/
package charge_cfg_pkg;
   // ===========================================================
   // Register map
   localparam logic [7:0] CC0_ADDR = 8'h14;
   localparam logic [7:0] TC_ADDR = 8'h15;
   localparam logic [7:0] CC0_RESET = 8'h06;
   localparam logic [7:0] TC_RESET = 8'h5C;
   localparam logic [7:0] CC0_REGRST_MASK = 8'h3F; // Fields restored by register reset
   localparam logic [7:0] CC0_WDOG_MASK = 8'h04;   // Fields restored by watchdog
   localparam logic [7:0] CC0_WRITE_MASK = 8'h7F;  // Bit 7 is read-only
   localparam logic [7:0] TC_REGRST_MASK = 8'hFF;
   localparam logic [7:0] TC_WDOG_MASK = 8'h74;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam logic [2:0] DCP_STATUS = 3'h3;       // Dedicated charging port code

   // ===========================================================
   // Analog figures
   localparam int TRACK_OFFSET_MV = 400;
   localparam int RECHG_SMALL_MV = 100;
   localparam int RECHG_LARGE_MV = 200;
   localparam logic [6:0] TRICKLE_LOW_MA = 7'h14;  // 20 mA
   localparam logic [6:0] TRICKLE_HIGH_MA = 7'h50; // 80 mA

   // ===========================================================
   // Timing
   localparam int CLK_HZ = 25_000_000;
   localparam int TICK_PERIOD_S = 1;
   localparam int TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
   localparam int TMR_W = 17;
   localparam int PRECHG_LONG_H = 2;
   localparam int PRECHG_SHORT_MIN = 30;
   localparam int FAST_SHORT_H = 12;
   localparam int FAST_LONG_H = 24;
   localparam int TOPOFF_STEP_MIN = 15;
   localparam logic [16:0] PRECHG_LONG_T = 17'(PRECHG_LONG_H * 3600 / TICK_PERIOD_S);
   localparam logic [16:0] PRECHG_SHORT_T = 17'(PRECHG_SHORT_MIN * 60 / TICK_PERIOD_S);
   localparam logic [16:0] FAST_SHORT_T = 17'(FAST_SHORT_H * 3600 / TICK_PERIOD_S);
   localparam logic [16:0] FAST_LONG_T = 17'(FAST_LONG_H * 3600 / TICK_PERIOD_S);
   localparam int TOPOFF_STEP_T = TOPOFF_STEP_MIN * 60 / TICK_PERIOD_S;

   // ===========================================================
   // Types
   typedef struct packed {
      logic input_switch_full_on;
      logic battery_switch_full_on;
      logic trickle_current_select;
      logic [1:0] top_off_timer_select;
      logic termination_enable;
      logic input_limit_battery_tracking;
      logic recharge_offset_select;
   } charge_ctrl_t;

   typedef struct packed {
      logic status_pin_disable;
      logic auto_source_detect_enable;
      logic forced_source_detect;
      logic dedicated_port_bias_enable;
      logic timer_slowdown_enable;
      logic safety_timers_enable;
      logic precharge_timer_select;
      logic fast_charge_timer_select;
   } timer_ctrl_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic regulation;
      logic detect_finished;
      logic vbus_present;
      logic battery_above_sysmin;
      logic input_switch_full_on;
   } pins_t;

   typedef struct packed {
      logic input_switch_low_res;
      logic battery_switch_low_res;
      logic [6:0] trickle_current_ma;
      logic termination_allowed;
      logic [15:0] vin_limit_eff_mv;
      logic [15:0] recharge_threshold_mv;
      logic stat_pin_oe;
      logic dplus_bias_on;
   } cfg_out_t;

   typedef enum logic [2:0] {
      CHG_IDLE = 3'h0,
      CHG_TRICKLE = 3'h1,
      CHG_PRE = 3'h3,
      CHG_FAST = 3'h2,
      CHG_TOPOFF = 3'h6
   } phase_t;

   typedef enum logic [1:0] {
      DET_IDLE = 2'h0,
      DET_RUN = 2'h1,
      DET_END = 2'h3
   } det_state_t;
endpackage

// ===== design/pin_sync.sv
/*
 Two-flop synchroniser for a group of asynchronous level inputs.
 Assumes the inputs are slow levels; no bus coherency is promised.
*/
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] held;
   } sync_state_t;

   sync_state_t s;
   sync_state_t next_s;

   // ===========================================================
   // Shift through two stages; only the second stage is visible
   always_comb begin
      next_s.meta = d;
      next_s.held = s.meta;
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign q = s.held;
endmodule

// ===== design/safety_timer.sv
/*
 Elapsed-time counter for one charge timer, counting one-second ticks.
 Assumes tick is a one-cycle enable from the core divider and that the
 limit is stable while run is high.
*/
`timescale 1ns/1ps
module safety_timer (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic run,
   input wire logic tick,
   input wire logic half_rate,
   input wire logic [16:0] limit,
   output logic expired
);
   typedef struct packed {
      logic [16:0] count;
      logic skip;
      logic expired;
   } tmr_state_t;

   tmr_state_t s;
   tmr_state_t next_s;

   // ===========================================================
   // Count ticks, every other one when slowed; clear when stopped
   always_comb begin
      next_s = s;
      if (!run) begin
         next_s = '0;
      end else if (tick && !s.expired) begin
         next_s.skip = half_rate ? !s.skip : 1'b0;
         if (!half_rate || s.skip) begin
            next_s.count = s.count + 17'h00001;
         end
      end
      next_s.expired = run && (s.count >= limit);
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign expired = s.expired;

   // ===========================================================
   // Checks
   stop_clears_a: assert property (@(posedge core_clk) disable iff (!rstn)
      !run |=> !expired) else $error("timer expired while stopped");
   slow_count_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (run && tick && half_rate && !s.skip && !s.expired) |=> $stable(s.count))
      else $error("slowed timer counted on a skipped tick");
endmodule

// ===== design/charge_ctrl_timer_config_regs.sv
/*
 Charge control and charge timer control registers of a single-cell charger,
 with the logic they steer: switch forcing, trickle current, input limit
 tracking, recharge threshold, status pin, D+/D- detection and safety timers.
 Assumes a serial slave outside hands over one-cycle byte accesses on the
 core clock, and that analog status levels arrive asynchronously.
*/
`timescale 1ns/1ps
module charge_ctrl_timer_config_regs #(
   parameter int TICK_CYCLES = charge_cfg_pkg::TICK_CYCLES
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire charge_cfg_pkg::reg_req_t reg_bus,
   output logic [7:0] reg_rd_data,
   input wire logic reg_reset,
   input wire logic watchdog_expired,
   input wire charge_cfg_pkg::pins_t pins_async,
   input wire charge_cfg_pkg::phase_t charge_phase,
   input wire logic charge_status_active,
   input wire logic [2:0] input_source_status,
   input wire logic [15:0] vin_limit_mv,
   input wire logic [15:0] vbat_mv,
   input wire logic [15:0] charge_regulation_voltage_mv,
   output charge_cfg_pkg::cfg_out_t cfg_out,
   output logic stat_pin_o,
   output logic detect_run,
   output logic precharge_expired,
   output logic fast_charge_expired,
   output logic top_off_expired
);
   typedef struct packed {
      charge_cfg_pkg::charge_ctrl_t cc0;
      charge_cfg_pkg::timer_ctrl_t tc;
      charge_cfg_pkg::det_state_t det;
      logic vbus_prev;
      logic [24:0] tick_cnt;
      logic tick;
      logic [7:0] rd_data;
      charge_cfg_pkg::cfg_out_t out;
   } state_t;

   state_t s;
   state_t next_s;
   charge_cfg_pkg::pins_t pins;
   logic wr_cc0;
   logic wr_tc;
   logic plug_in;
   logic half_rate;
   logic pre_run;
   logic fast_run;
   logic topoff_run;
   logic [16:0] pre_limit;
   logic [16:0] fast_limit;
   logic [16:0] topoff_limit;

   // ===========================================================
   // Synchronise analog status levels
   pin_sync #(
      .W(5)
   ) u_pin_sync (
      .core_clk(core_clk),
      .rstn(rstn),
      .d(pins_async),
      .q(pins)
   );

   // ===========================================================
   // Write strobes and derived events
   assign wr_cc0 = reg_bus.wr && (reg_bus.addr == charge_cfg_pkg::CC0_ADDR);
   assign wr_tc = reg_bus.wr && (reg_bus.addr == charge_cfg_pkg::TC_ADDR);
   assign plug_in = pins.vbus_present && !s.vbus_prev;
   assign half_rate = s.tc.timer_slowdown_enable && pins.regulation;

   // ===========================================================
   // Next-state logic for registers, detection and outputs
   always_comb begin
      next_s = s;
      next_s.vbus_prev = pins.vbus_present;

      // One-second tick from the core clock
      next_s.tick = 1'b0;
      if (s.tick_cnt == 25'(TICK_CYCLES - 1)) begin
         next_s.tick_cnt = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.tick_cnt = s.tick_cnt + 25'h0000001;
      end

      // Watchdog restores only its own subset of fields
      if (watchdog_expired) begin
         next_s.cc0 = charge_cfg_pkg::charge_ctrl_t'(
            (8'(s.cc0) & ~charge_cfg_pkg::CC0_WDOG_MASK) |
            (charge_cfg_pkg::CC0_RESET & charge_cfg_pkg::CC0_WDOG_MASK));
         next_s.tc = charge_cfg_pkg::timer_ctrl_t'(
            (8'(s.tc) & ~charge_cfg_pkg::TC_WDOG_MASK) |
            (charge_cfg_pkg::TC_RESET & charge_cfg_pkg::TC_WDOG_MASK));
      end

      // Register reset restores every field that it covers
      if (reg_reset) begin
         next_s.cc0 = charge_cfg_pkg::charge_ctrl_t'(
            (8'(next_s.cc0) & ~charge_cfg_pkg::CC0_REGRST_MASK) |
            (charge_cfg_pkg::CC0_RESET & charge_cfg_pkg::CC0_REGRST_MASK));
         next_s.tc = charge_cfg_pkg::timer_ctrl_t'(
            (8'(next_s.tc) & ~charge_cfg_pkg::TC_REGRST_MASK) |
            (charge_cfg_pkg::TC_RESET & charge_cfg_pkg::TC_REGRST_MASK));
      end

      // Host writes; the read-only bit keeps its value
      if (wr_cc0) begin
         next_s.cc0 = charge_cfg_pkg::charge_ctrl_t'(
            (8'(s.cc0) & ~charge_cfg_pkg::CC0_WRITE_MASK) |
            (reg_bus.wdata & charge_cfg_pkg::CC0_WRITE_MASK));
      end
      if (wr_tc) begin
         next_s.tc = charge_cfg_pkg::timer_ctrl_t'(reg_bus.wdata);
      end

      // Read-only switch state follows the power stage
      next_s.cc0.input_switch_full_on = pins.input_switch_full_on;

      // D+/D- detection sequence
      case (s.det)
         charge_cfg_pkg::DET_IDLE: begin
            if ((plug_in && s.tc.auto_source_detect_enable) ||
                s.tc.forced_source_detect) begin
               next_s.det = charge_cfg_pkg::DET_RUN;
            end
         end
         charge_cfg_pkg::DET_RUN: begin
            if (pins.detect_finished) begin
               next_s.det = charge_cfg_pkg::DET_END;
            end
         end
         charge_cfg_pkg::DET_END: begin
            // A host write of 1 in this cycle wins over the self-clear
            if (!(wr_tc && reg_bus.wdata[5])) begin
               next_s.tc.forced_source_detect = 1'b0;
            end
            next_s.det = charge_cfg_pkg::DET_IDLE;
         end
         default: begin
            next_s.det = charge_cfg_pkg::DET_IDLE;
         end
      endcase

      // Register read port answers the cycle after the strobe
      if (reg_bus.rd) begin
         case (reg_bus.addr)
            charge_cfg_pkg::CC0_ADDR: next_s.rd_data = 8'(s.cc0);
            charge_cfg_pkg::TC_ADDR: next_s.rd_data = 8'(s.tc);
            default: next_s.rd_data = charge_cfg_pkg::UNMAPPED_READ;
         endcase
      end

      // Registered controls toward the power stage
      next_s.out.input_switch_low_res = s.cc0.input_switch_full_on;
      next_s.out.battery_switch_low_res =
         s.cc0.battery_switch_full_on && pins.battery_above_sysmin;
      next_s.out.trickle_current_ma = s.cc0.trickle_current_select ?
         charge_cfg_pkg::TRICKLE_HIGH_MA : charge_cfg_pkg::TRICKLE_LOW_MA;
      next_s.out.termination_allowed = s.cc0.termination_enable;
      next_s.out.vin_limit_eff_mv = vin_limit_mv;
      if (s.cc0.input_limit_battery_tracking &&
          (17'(vbat_mv) + 17'(charge_cfg_pkg::TRACK_OFFSET_MV) > 17'(vin_limit_mv))) begin
         next_s.out.vin_limit_eff_mv =
            16'(vbat_mv + 16'(charge_cfg_pkg::TRACK_OFFSET_MV));
      end
      next_s.out.recharge_threshold_mv = s.cc0.recharge_offset_select ?
         16'(charge_regulation_voltage_mv - 16'(charge_cfg_pkg::RECHG_LARGE_MV)) :
         16'(charge_regulation_voltage_mv - 16'(charge_cfg_pkg::RECHG_SMALL_MV));
      next_s.out.stat_pin_oe =
         charge_status_active && !s.tc.status_pin_disable;
      next_s.out.dplus_bias_on = s.tc.dedicated_port_bias_enable &&
         (input_source_status == charge_cfg_pkg::DCP_STATUS);
   end

   // ===========================================================
   // State register with documented reset values
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         s <= '0;
         s.cc0 <= charge_cfg_pkg::charge_ctrl_t'(charge_cfg_pkg::CC0_RESET);
         s.tc <= charge_cfg_pkg::timer_ctrl_t'(charge_cfg_pkg::TC_RESET);
         s.out.trickle_current_ma <= charge_cfg_pkg::TRICKLE_LOW_MA;
         s.out.termination_allowed <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ===========================================================
   // Safety and top-off timers
   assign pre_run = s.tc.safety_timers_enable &&
      ((charge_phase == charge_cfg_pkg::CHG_TRICKLE) ||
       (charge_phase == charge_cfg_pkg::CHG_PRE));
   assign fast_run = s.tc.safety_timers_enable &&
      (charge_phase == charge_cfg_pkg::CHG_FAST);
   assign topoff_run = (s.cc0.top_off_timer_select != 2'h0) &&
      (charge_phase == charge_cfg_pkg::CHG_TOPOFF);
   assign pre_limit = s.tc.precharge_timer_select ?
      charge_cfg_pkg::PRECHG_SHORT_T : charge_cfg_pkg::PRECHG_LONG_T;
   assign fast_limit = s.tc.fast_charge_timer_select ?
      charge_cfg_pkg::FAST_LONG_T : charge_cfg_pkg::FAST_SHORT_T;
   assign topoff_limit = 17'(32'(s.cc0.top_off_timer_select) *
      charge_cfg_pkg::TOPOFF_STEP_T);

   safety_timer u_pre_timer (
      .core_clk(core_clk),
      .rstn(rstn),
      .run(pre_run),
      .tick(s.tick),
      .half_rate(half_rate),
      .limit(pre_limit),
      .expired(precharge_expired)
   );

   safety_timer u_fast_timer (
      .core_clk(core_clk),
      .rstn(rstn),
      .run(fast_run),
      .tick(s.tick),
      .half_rate(half_rate),
      .limit(fast_limit),
      .expired(fast_charge_expired)
   );

   safety_timer u_topoff_timer (
      .core_clk(core_clk),
      .rstn(rstn),
      .run(topoff_run),
      .tick(s.tick),
      .half_rate(1'b0),
      .limit(topoff_limit),
      .expired(top_off_expired)
   );

   // ===========================================================
   // Outputs
   assign reg_rd_data = s.rd_data;
   assign cfg_out = s.out;
   assign stat_pin_o = 1'b0; // Open drain: pulls low when enabled
   assign detect_run = (s.det == charge_cfg_pkg::DET_RUN);

   // ===========================================================
   // Checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   sequence det_start_s;
      (s.det == charge_cfg_pkg::DET_IDLE) && s.tc.forced_source_detect;
   endsequence

   sequence det_finish_s;
      (s.det == charge_cfg_pkg::DET_RUN) && pins.detect_finished && !reg_bus.wr;
   endsequence

   cc0_reset_a: assert property (@(posedge core_clk) disable iff (1'b0)
      !rstn |=> 8'(s.cc0) == charge_cfg_pkg::CC0_RESET)
      else $error("charge control reset value wrong");
   tc_reset_a: assert property (@(posedge core_clk) disable iff (1'b0)
      !rstn |=> 8'(s.tc) == charge_cfg_pkg::TC_RESET)
      else $error("timer control reset value wrong");
   ro_bit_a: assert property (wr_cc0 |=>
      s.cc0.input_switch_full_on == $past(pins.input_switch_full_on))
      else $error("read-only switch bit took host data");
   wdog_restore_a: assert property ((watchdog_expired && !reg_bus.wr) |=>
      s.tc.safety_timers_enable && s.cc0.termination_enable &&
      s.tc.auto_source_detect_enable && !s.tc.forced_source_detect)
      else $error("watchdog did not restore defaults");
   trickle_reset_a: assert property ((reg_reset && !reg_bus.wr) |=> ##1
      cfg_out.trickle_current_ma == charge_cfg_pkg::TRICKLE_LOW_MA)
      else $error("trickle current not back to default");
   force_start_a: assert property (det_start_s |=> detect_run)
      else $error("forced detection did not start");
   force_clear_a: assert property (det_finish_s ##1 !reg_bus.wr |=>
      !s.tc.forced_source_detect && !detect_run)
      else $error("forced detection bit did not self-clear");
   auto_det_a: assert property ((s.det == charge_cfg_pkg::DET_IDLE && plug_in &&
      s.tc.auto_source_detect_enable) |=> detect_run)
      else $error("plug-in did not start detection");
   track_a: assert property (s.cc0.input_limit_battery_tracking |=>
      cfg_out.vin_limit_eff_mv >= $past(vin_limit_mv))
      else $error("effective input limit below programmed limit");
   bias_a: assert property ((input_source_status != charge_cfg_pkg::DCP_STATUS) |=>
      !cfg_out.dplus_bias_on)
      else $error("bias applied without dedicated port");
   stat_off_a: assert property (s.tc.status_pin_disable |=> !cfg_out.stat_pin_oe)
      else $error("status pin driven while disabled");
endmodule

// ===== tb/detect_partner.sv
/*
 Power-stage stand-in that answers D+/D- detection runs.
 Assumes detect_run is a registered level of the device on core_clk.
*/
`timescale 1ns/1ps
module detect_partner (
   input wire logic core_clk,
   input wire logic detect_run,
   input wire logic slow,
   output logic finished
);
   int cnt;
   initial begin
      cnt = 0;
      finished = 1'b0;
   end
   // Ends a run after a short or a long delay, and drops the flag once the run stops
   always @(posedge core_clk) begin
      if (!detect_run) begin
         cnt <= 0;
         finished <= 1'b0;
      end else begin
         cnt <= cnt + 1;
         if (cnt >= (slow ? 20 : 2)) begin
            finished <= 1'b1;
         end
      end
   end
endmodule

// ===== tb/tb.sv
/*
 Self-checking bench of the charge configuration register bank.
 Assumes the design package is compiled first and the detection partner beside it.
*/
`timescale 1ns/1ps
module tb;
   logic core_clk, rstn, reg_reset, wdog, act, q1, vbus, above, regul, slow, run, fin;
   logic [7:0] rdata, d, t;
   logic [2:0] src;
   logic [15:0] vin, vbat, charge_regulation_voltage;
   wire [2:0] xp;
   int n_mismatch, compares, i;
   charge_cfg_pkg::reg_req_t bus;
   charge_cfg_pkg::phase_t ph;
   charge_cfg_pkg::pins_t pins;
   charge_cfg_pkg::cfg_out_t co;
   assign pins = {regul, fin, vbus, above, q1};
   // Device under test and its detection partner
   charge_ctrl_timer_config_regs #(.TICK_CYCLES(1)) charge_ctrl_timer_config_regs_inst (
      .core_clk(core_clk), .rstn(rstn), .reg_bus(bus), .reg_rd_data(rdata),
      .reg_reset(reg_reset), .watchdog_expired(wdog), .pins_async(pins), .charge_phase(ph),
      .charge_status_active(act), .input_source_status(src), .vin_limit_mv(vin),
      .vbat_mv(vbat), .charge_regulation_voltage_mv(charge_regulation_voltage), .cfg_out(co), .stat_pin_o(), .detect_run(run),
      .precharge_expired(xp[0]), .fast_charge_expired(xp[1]), .top_off_expired(xp[2]));
   detect_partner detect_partner_inst (.core_clk(core_clk), .detect_run(run),
      .slow(slow), .finished(fin));
   // ===========================================================
   // Helpers
   function automatic logic [15:0] eff(logic trk, logic [15:0] v, logic [15:0] b);
      eff = (trk && (b + 16'd400) > v) ? b + 16'd400 : v;
   endfunction
   task chk(string nm, logic [15:0] e, logic [15:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task step(int n);
      repeat (n) @(posedge core_clk);
   endtask
   task wr(logic [7:0] a, logic [7:0] v);
      @(posedge core_clk) bus <= {1'b1, 1'b0, a, v};
      @(posedge core_clk) bus <= '0;
   endtask
   task rd(logic [7:0] a, logic [7:0] e);
      @(posedge core_clk) bus <= {1'b0, 1'b1, a, 8'h00};
      @(posedge core_clk) bus <= '0;
      #1 chk($sformatf("reg %h", a), 16'(e), 16'(rdata));
   endtask
   task wait_run(logic v, int n);
      for (int k = 0; k < n && run !== v; k++) begin
         @(posedge core_clk);
         #1;
      end
      #1 chk("detect_run", 16'(v), 16'(run));
   endtask
   task tm(charge_cfg_pkg::phase_t p, int n, logic [2:0] e);
      @(posedge core_clk) ph <= p;
      step(n - 5);
      #1 chk("expired early", 16'h0000, 16'(xp));
      step(13);
      #1 chk("expired", 16'(e), 16'(xp));
      @(posedge core_clk) ph <= charge_cfg_pkg::CHG_IDLE;
      step(3);
   endtask
   task end_of_test;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ===========================================================
   // Clock and hang guard
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   initial begin
      #3_000_000;
      n_mismatch++;
      end_of_test();
   end
   // ===========================================================
   // Main sequence
   initial begin
      {rstn, reg_reset, wdog, act, q1, vbus, above, regul, slow} = '0;
      {bus, src, vin, vbat, charge_regulation_voltage} = '0;
      ph = charge_cfg_pkg::CHG_IDLE;
      void'($urandom(32'hF0CB066A));
      step(5);
      @(posedge core_clk) rstn <= 1'b1;
      step(2);
      rd(8'h14, 8'h06);
      rd(8'h15, 8'h5C);
      chk("trickle", 16'h0014, 16'(co.trickle_current_ma));
      // Corner values first, then random settings and analog levels
      for (i = 0; i < 14; i++) begin
         d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
         t = ((i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom)) & 8'hDF;
         @(posedge core_clk) {q1, above, act, regul} <= 4'($urandom);
         vin <= 16'($urandom);
         vbat <= 16'($urandom) & 16'h3FFF;
         charge_regulation_voltage <= 16'($urandom);
         src <= (i < 2) ? 3'h3 : 3'($urandom);
         wr(8'h14, d);
         wr(8'h15, t);
         step(3);
         rd(8'h14, {q1, d[6:0]});
         rd(8'h15, t);
         chk("input switch", 16'(q1), 16'(co.input_switch_low_res));
         chk("battery switch", 16'(d[6] & above), 16'(co.battery_switch_low_res));
         chk("trickle", d[5] ? 16'h0050 : 16'h0014, 16'(co.trickle_current_ma));
         chk("termination", 16'(d[2]), 16'(co.termination_allowed));
         chk("vin limit", eff(d[1], vin, vbat), co.vin_limit_eff_mv);
         chk("recharge", charge_regulation_voltage - (d[0] ? 16'd200 : 16'd100), co.recharge_threshold_mv);
         chk("stat oe", 16'(~t[7] & act), 16'(co.stat_pin_oe));
         chk("bias", 16'(t[4] && src == 3'h3), 16'(co.dplus_bias_on));
      end
      // Watchdog subset, then register reset
      wr(8'h14, 8'h79);
      wr(8'h15, 8'h83);
      @(posedge core_clk) wdog <= 1'b1;
      @(posedge core_clk) wdog <= 1'b0;
      step(2);
      rd(8'h14, {q1, 7'h7D});
      rd(8'h15, 8'hD7);
      @(posedge core_clk) reg_reset <= 1'b1;
      @(posedge core_clk) reg_reset <= 1'b0;
      step(2);
      rd(8'h14, {q1, 7'h46});
      rd(8'h15, 8'h5C);
      // Plug-in detection on and off, then forced detection
      @(posedge core_clk) vbus <= 1'b1;
      wait_run(1'b1, 10);
      wait_run(1'b0, 40);
      @(posedge core_clk) vbus <= 1'b0;
      wr(8'h15, 8'h1C);
      step(4);
      @(posedge core_clk) vbus <= 1'b1;
      step(10);
      chk("detect_run", 16'h0000, 16'(run));
      @(posedge core_clk) slow <= 1'b1;
      wr(8'h15, 8'h3C);
      wait_run(1'b1, 5);
      rd(8'h15, 8'h3C);
      wait_run(1'b0, 60);
      step(3);
      rd(8'h15, 8'h1C);
      // Safety, top-off and slowed timers
      @(posedge core_clk) regul <= 1'b0;
      wr(8'h14, 8'h0E);
      wr(8'h15, 8'h5C);
      tm(charge_cfg_pkg::CHG_PRE, 7200, 3'b001);
      tm(charge_cfg_pkg::CHG_FAST, 43200, 3'b010);
      tm(charge_cfg_pkg::CHG_TOPOFF, 900, 3'b100);
      wr(8'h14, 8'h1E);
      tm(charge_cfg_pkg::CHG_TOPOFF, 2700, 3'b100);
      wr(8'h15, 8'h5E);
      tm(charge_cfg_pkg::CHG_TRICKLE, 1800, 3'b001);
      @(posedge core_clk) regul <= 1'b1;
      tm(charge_cfg_pkg::CHG_PRE, 3600, 3'b001);
      wr(8'h15, 8'h5A);
      tm(charge_cfg_pkg::CHG_PRE, 3600, 3'b000);
      end_of_test();
   end
endmodule
